// [rtl/pirq_defs.svh]
// Register offsets, field positions and reset values of the peripheral interrupt enable block
`ifndef PIRQ_DEFS_SVH
`define PIRQ_DEFS_SVH

// Register byte offsets
`define PIRQ_OFF_ENABLE 4'h0
`define PIRQ_OFF_CONTROL 4'h4
`define PIRQ_OFF_FLAGS 4'h8
`define PIRQ_OFF_STATUS 4'hc
`define PIRQ_OFF_CLEAR 4'h0
`define PIRQ_OFF_IRQ_EN 4'h4
`define PIRQ_ADDR_W 5

// Full byte addresses (bit 4 selects the upper bank)
`define PIRQ_ADDR_ENABLE 5'h00
`define PIRQ_ADDR_CONTROL 5'h04
`define PIRQ_ADDR_FLAGS 5'h08
`define PIRQ_ADDR_STATUS 5'h0c
`define PIRQ_ADDR_CLEAR 5'h10
`define PIRQ_ADDR_IRQ_EN 5'h14

// Enable register bit positions
`define PIRQ_BIT_TIMER_ONE_GATE 7
`define PIRQ_BIT_ADC 6
`define PIRQ_BIT_SERIAL_RX 5
`define PIRQ_BIT_SERIAL_TX 4
`define PIRQ_BIT_SYNC_SERIAL 3
`define PIRQ_BIT_CAPCOMP_ONE 2
`define PIRQ_BIT_TIMER_TWO_MATCH 1
`define PIRQ_BIT_TIMER_ONE_OVERFLOW 0

// Control register bit positions
`define PIRQ_BIT_GLOBAL_EN 7
`define PIRQ_BIT_GROUP_EN 6

// Reset values
`define PIRQ_RST_ENABLE 8'h00
`define PIRQ_RST_CONTROL 8'h00
`define PIRQ_RST_STATUS 8'h00
`define PIRQ_RST_IRQ_EN 8'h00

`endif

// [rtl/pirq_pkg.sv]
// Types shared by the peripheral interrupt enable block
package pirq_pkg;
   typedef logic [7:0] pirq_byte_t;
   typedef enum logic [1:0] {
      PIRQ_RESP_OKAY = 2'h0,
      PIRQ_RESP_DECERR = 2'h3
   } pirq_resp_t;
endpackage

// [rtl/pirq_enable.sv]
// Peripheral interrupt enable register with gating and an AXI4-Lite slave
// Notes on behaviour
// - Eight-bit read/write enable register, one bit per peripheral source, cleared on reset.
// - No enabled peripheral interrupt reaches o_gated_flags or o_periph_irq_req unless the peripheral group enable is set.
// - Sync serial port interrupt reaches o_gated_flags and o_periph_irq_req only while its enable bit is set.
// - Serial receive interrupt reaches o_gated_flags and o_periph_irq_req only while its enable bit is set.
// - Capture/compare one interrupt reaches o_gated_flags and o_periph_irq_req only while its enable bit is set.
`timescale 1ns/1ps
`include "pirq_defs.svh"

module pirq_enable (
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire logic [7:0] i_periph_flags,
   output logic [7:0] o_gated_flags,
   output logic o_periph_irq_req,
   output logic o_irq,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp
);

   ////////////////////////////////////////////////////////////////////////////////////////////
   // State

   pirq_pkg::pirq_byte_t enable_reg;
   pirq_pkg::pirq_byte_t control_reg;
   pirq_pkg::pirq_byte_t status_reg;
   pirq_pkg::pirq_byte_t irq_en_reg;
   pirq_pkg::pirq_byte_t flags_prev;
   logic aw_held;
   logic w_held;
   logic [31:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;

   // Address decode shared by both channels
   function automatic logic addr_hit(input logic [31:0] addr, input logic [4:0] reg_addr);
      addr_hit = (addr[31:2] == {27'h0, reg_addr[4:2]});
   endfunction

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Gating of peripheral flags

   wire global_en = control_reg[`PIRQ_BIT_GLOBAL_EN];
   wire group_en = control_reg[`PIRQ_BIT_GROUP_EN];
   wire [7:0] flags_enabled = i_periph_flags & enable_reg;
   wire [7:0] next_gated_flags = flags_enabled & {8{group_en}};
   wire next_periph_irq_req = global_en & (|next_gated_flags);
   wire [7:0] flag_rise = i_periph_flags & ~flags_prev;

   // Registered gated outputs
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         o_gated_flags <= 8'h00;
         o_periph_irq_req <= 1'b0;
         flags_prev <= 8'h00;
      end else begin
         o_gated_flags <= next_gated_flags;
         o_periph_irq_req <= next_periph_irq_req;
         flags_prev <= i_periph_flags;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Write channel

   assign s_axi_awready = ~aw_held;
   assign s_axi_wready = ~w_held;
   wire do_write = aw_held & w_held & ~s_axi_bvalid;
   wire wr_lane0 = do_write & w_strb[0];
   wire wr_enable = wr_lane0 & addr_hit(aw_addr, `PIRQ_ADDR_ENABLE);
   wire wr_control = wr_lane0 & addr_hit(aw_addr, `PIRQ_ADDR_CONTROL);
   wire wr_clear = wr_lane0 & addr_hit(aw_addr, `PIRQ_ADDR_CLEAR);
   wire wr_irq_en = wr_lane0 & addr_hit(aw_addr, `PIRQ_ADDR_IRQ_EN);
   wire wr_mapped = addr_hit(aw_addr, `PIRQ_ADDR_ENABLE) | addr_hit(aw_addr, `PIRQ_ADDR_CONTROL)
      | addr_hit(aw_addr, `PIRQ_ADDR_FLAGS) | addr_hit(aw_addr, `PIRQ_ADDR_STATUS)
      | addr_hit(aw_addr, `PIRQ_ADDR_CLEAR) | addr_hit(aw_addr, `PIRQ_ADDR_IRQ_EN);
   wire [7:0] clear_bits = wr_clear ? w_data[7:0] : 8'h00;
   wire [7:0] next_status = (status_reg & ~clear_bits) | flag_rise; // Set wins over clear

   // Address and data capture, response
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 32'h0;
         w_data <= 32'h0;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end else begin
         if (s_axi_awvalid && !aw_held) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_held) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_mapped ? pirq_pkg::PIRQ_RESP_OKAY : pirq_pkg::PIRQ_RESP_DECERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Software registers
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         enable_reg <= `PIRQ_RST_ENABLE;
         control_reg <= `PIRQ_RST_CONTROL;
         irq_en_reg <= `PIRQ_RST_IRQ_EN;
         status_reg <= `PIRQ_RST_STATUS;
      end else begin
         if (wr_enable) begin
            enable_reg <= w_data[7:0];
         end
         if (wr_control) begin
            control_reg <= w_data[7:0] & 8'hc0;
         end
         if (wr_irq_en) begin
            irq_en_reg <= w_data[7:0];
         end
         status_reg <= next_status;
      end
   end

   // Level interrupt from enabled sticky events
   assign o_irq = |(status_reg & irq_en_reg);

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Read channel

   assign s_axi_arready = ~s_axi_rvalid;
   wire rd_take = s_axi_arvalid & ~s_axi_rvalid;
   wire rd_enable = addr_hit(s_axi_araddr, `PIRQ_ADDR_ENABLE);
   wire rd_control = addr_hit(s_axi_araddr, `PIRQ_ADDR_CONTROL);
   wire rd_flags = addr_hit(s_axi_araddr, `PIRQ_ADDR_FLAGS);
   wire rd_status = addr_hit(s_axi_araddr, `PIRQ_ADDR_STATUS);
   wire rd_irq_en = addr_hit(s_axi_araddr, `PIRQ_ADDR_IRQ_EN);
   wire rd_clear = addr_hit(s_axi_araddr, `PIRQ_ADDR_CLEAR);
   wire rd_mapped = rd_enable | rd_control | rd_flags | rd_status | rd_irq_en | rd_clear;
   wire [7:0] rd_byte = ({8{rd_enable}} & enable_reg) | ({8{rd_control}} & control_reg)
      | ({8{rd_flags}} & i_periph_flags) | ({8{rd_status}} & status_reg)
      | ({8{rd_irq_en}} & irq_en_reg);

   // Read data and response
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= 2'h0;
      end else if (rd_take) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {24'h0, rd_byte};
         s_axi_rresp <= rd_mapped ? pirq_pkg::PIRQ_RESP_OKAY : pirq_pkg::PIRQ_RESP_DECERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Checks

   enable_reset_a: assert property (@(posedge i_sys_clk) i_reset |=> enable_reg == 8'h00)
      else $error("enable register not cleared by reset");

   enable_write_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      wr_enable |=> enable_reg == $past(w_data[7:0]))
      else $error("enable register did not take written value");

   group_gate_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      !group_en |=> o_gated_flags == 8'h00 && !o_periph_irq_req)
      else $error("interrupt passed without group enable");

   sync_serial_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      ##1 o_gated_flags[`PIRQ_BIT_SYNC_SERIAL] == ($past(i_periph_flags[`PIRQ_BIT_SYNC_SERIAL])
      & $past(enable_reg[`PIRQ_BIT_SYNC_SERIAL]) & $past(group_en)))
      else $error("sync serial gating wrong");

   serial_rx_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      ##1 o_gated_flags[`PIRQ_BIT_SERIAL_RX] == ($past(i_periph_flags[`PIRQ_BIT_SERIAL_RX])
      & $past(enable_reg[`PIRQ_BIT_SERIAL_RX]) & $past(group_en)))
      else $error("serial receive gating wrong");

   capcomp_one_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      ##1 o_gated_flags[`PIRQ_BIT_CAPCOMP_ONE] == ($past(i_periph_flags[`PIRQ_BIT_CAPCOMP_ONE])
      & $past(enable_reg[`PIRQ_BIT_CAPCOMP_ONE]) & $past(group_en)))
      else $error("capture compare gating wrong");

   request_all_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      ##1 o_periph_irq_req == ($past(global_en) & $past(group_en)
      & (|($past(i_periph_flags) & $past(enable_reg)))))
      else $error("request does not match flag and enables");

   bresp_hold_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before taken");

   status_set_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      flag_rise != 8'h00 |=> (status_reg & $past(flag_rise)) == $past(flag_rise))
      else $error("event lost against clear");

endmodule

// [verification/pirq_periph_model.sv]
// Peripheral flag sources that feed the interrupt enable block
`timescale 1ns/1ps

module pirq_periph_model (
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire logic [7:0] i_raise,
   output logic [7:0] o_flags
);
   // Flags follow the requested level one edge later
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         o_flags <= 8'h00;
      end else begin
         o_flags <= i_raise;
      end
   end
endmodule

// [verification/pirq_enable_tb_top.sv]
// Self-checking bench for the peripheral interrupt enable block
`timescale 1ns/1ps
`include "pirq_defs.svh"

module pirq_enable_tb_top;
   localparam logic [1:0] ok = pirq_pkg::PIRQ_RESP_OKAY;
   localparam logic [1:0] de = pirq_pkg::PIRQ_RESP_DECERR;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] raise = 8'h00;
   logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
   logic [31:0] awa = 32'h0, wd = 32'h0, ara = 32'h0;
   logic [3:0] ws = 4'hf;
   logic [7:0] flags, gated;
   logic req, irq, awr, wrr, bv, arr, rv;
   logic [1:0] br, rr;
   logic [31:0] rdat;
   int fail_count = 0;
   int check_count = 0;
   int cyc = 0;

   ////////////////////////////////////////////////////////////////////////////////
   // Clock and hang ceiling
   always #50 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         report_and_stop();
      end
   end

   pirq_periph_model model (.i_sys_clk(clk), .i_reset(rst), .i_raise(raise), .o_flags(flags));

   pirq_enable dut (.i_sys_clk(clk), .i_reset(rst), .i_periph_flags(flags),
      .o_gated_flags(gated), .o_periph_irq_req(req), .o_irq(irq),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
      .s_axi_wvalid(wv), .s_axi_wready(wrr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
      .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_bresp(br),
      .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
      .s_axi_rvalid(rv), .s_axi_rready(rry), .s_axi_rdata(rdat), .s_axi_rresp(rr));

   ////////////////////////////////////////////////////////////////////////////////
   // Verdict and comparison
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Bus write: address and data offered together, each dropped when taken
   task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] e);
      @(posedge clk);
      awa <= {27'h0, a};
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bry <= 1'b1;
      do begin
         @(posedge clk);
         if (awr) awv <= 1'b0;
         if (wrr) wv <= 1'b0;
      end while (!bv);
      bry <= 1'b0;
      chk(32'(br), 32'(e));
   endtask

   // Bus read with data and response compare
   task automatic rd(input logic [4:0] a, input logic [31:0] x, input logic [1:0] e);
      @(posedge clk);
      ara <= {27'h0, a};
      arv <= 1'b1;
      rry <= 1'b1;
      do begin
         @(posedge clk);
         if (arr) arv <= 1'b0;
      end while (!rv);
      rry <= 1'b0;
      chk(rdat, x);
      chk(32'(rr), 32'(e));
   endtask

   task automatic settle();
      repeat (3) @(posedge clk);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      rd(`PIRQ_ADDR_ENABLE, 32'h0, ok);
      rd(`PIRQ_ADDR_CONTROL, 32'h0, ok);
      rd(`PIRQ_ADDR_IRQ_EN, 32'h0, ok);
      wr(`PIRQ_ADDR_ENABLE, 32'hffff_ff5a, ok);
      rd(`PIRQ_ADDR_ENABLE, 32'h5a, ok);
      // Write with the low byte lane off leaves the register alone
      ws <= 4'h0;
      wr(`PIRQ_ADDR_ENABLE, 32'h00, ok);
      ws <= 4'hf;
      rd(`PIRQ_ADDR_ENABLE, 32'h5a, ok);
      wr(5'h18, 32'hff, de);
      rd(5'h18, 32'h0, de);
      raise <= 8'hff;
      // Walk a single enable through every source
      for (int i = 0; i < 8; i++) begin
         wr(`PIRQ_ADDR_ENABLE, 32'(8'h01 << i), ok);
         wr(`PIRQ_ADDR_CONTROL, 32'h40, ok);
         settle();
         chk(32'(gated), 32'(8'h01 << i));
         chk(32'(req), 32'h0);
         wr(`PIRQ_ADDR_CONTROL, 32'hc0, ok);
         settle();
         chk(32'(req), 32'h1);
         wr(`PIRQ_ADDR_CONTROL, 32'h80, ok);
         settle();
         chk(32'(gated), 32'h0);
         chk(32'(req), 32'h0);
      end
      // Blocked sources raise flags with no request
      wr(`PIRQ_ADDR_CONTROL, 32'hc0, ok);
      wr(`PIRQ_ADDR_ENABLE, 32'hd3, ok);
      settle();
      chk(32'(gated), 32'hd3);
      raise <= 8'h2c;
      settle();
      chk(32'(gated), 32'h0);
      chk(32'(req), 32'h0);
      // Sticky status, mask and clear
      rd(`PIRQ_ADDR_FLAGS, 32'h2c, ok);
      rd(`PIRQ_ADDR_STATUS, 32'hff, ok);
      chk(32'(irq), 32'h0);
      wr(`PIRQ_ADDR_IRQ_EN, 32'h08, ok);
      chk(32'(irq), 32'h1);
      wr(`PIRQ_ADDR_CLEAR, 32'h08, ok);
      chk(32'(irq), 32'h0);
      rd(`PIRQ_ADDR_STATUS, 32'hf7, ok);
      wr(`PIRQ_ADDR_STATUS, 32'h0, ok);
      rd(`PIRQ_ADDR_STATUS, 32'hf7, ok);
      rd(`PIRQ_ADDR_CLEAR, 32'h0, ok);
      // Reset in mid-run clears a non-zero enable register again
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rd(`PIRQ_ADDR_ENABLE, 32'h0, ok);
      rd(`PIRQ_ADDR_CONTROL, 32'h0, ok);
      report_and_stop();
   end
endmodule
